// ---- rtl/lcrd_defines.svh ----
// constants of the lcd column and row driver front end: sizes, offsets, reset values
`ifndef LCRD_DEFINES_SVH
`define LCRD_DEFINES_SVH

// number of drive outputs and half-chain length
`define LCRD_NUM_OUT 160
`define LCRD_HALF 80

// column groups per line in 4-bit and 8-bit format, and last group index
`define LCRD_LAST_GRP4 6'h27
`define LCRD_LAST_GRP8 6'h13

// register byte offsets on the apb bus
`define LCRD_CTRL_OFS 8'h00
`define LCRD_STATUS_OFS 8'h04

// control register field position and reset value
`define LCRD_CTRL_RUN_BIT 0
`define LCRD_CTRL_RESET 32'h00000001

// status register field positions
`define LCRD_STAT_COLMODE_BIT 0
`define LCRD_STAT_COUNT_LSB 1
`define LCRD_STAT_STATE_LSB 7
`define LCRD_STAT_CHAININ_BIT 9
`define LCRD_STAT_FIFO_LSB 10

`endif

// ---- rtl/lcrd_driver.sv ----
// lcd column and row driver front end with apb status and control
`timescale 1ns/10ps
`default_nettype none
`include "lcrd_defines.svh"

// Summary of operation
// [RULE1] mode select high column, low row
// [RULE2] display off forces all outputs level_5
// [RULE3] column: latch line on latch falling edge
// [RULE4] chain in low plus clock.latch high enables
// [RULE5] system ties first chain input low
// [RULE6] column: direction picks chain input and output
// [RULE7] format selects 4 or 8 bit groups
// [RULE8] direction sets group to output mapping
// [RULE9] frame and data select drive level
// [RULE10] row: latch pulse shifts token one place
// [RULE11] column: shift clock takes one group
// [RULE12] row: direction picks token input and output
// [RULE13] row single chain over all 160 outputs
// [RULE14] row dual: eighth input feeds second half
// [RULE15] row: shift clock input held fixed
// [RULE16] after full line pass enable, ignore data
// [RULE17] chain output is one shift-clock pulse
module lcrd_driver (
  input wire logic pclk,                // system clock, 25 MHz
  input wire logic presetn,             // async reset, active low
  input wire logic [7:0] paddr,         // apb address
  input wire logic psel,                // apb select
  input wire logic penable,             // apb enable
  input wire logic pwrite,              // apb direction
  input wire logic [31:0] pwdata,       // apb write data
  output logic [31:0] prdata,           // apb read data
  output logic pready,                  // apb ready
  output logic pslverr,                 // apb error on unmapped address
  input wire logic mode_select,         // column or row mode pin
  input wire logic shift_dir,           // direction pin
  input wire logic data_format_select,  // format pin
  input wire logic display_off_n,       // display off pin
  input wire logic frame_polarity,      // frame pin
  input wire logic shift_clock,         // column shift clock pin
  input wire logic latch_pulse,         // latch pulse pin
  input wire logic [7:0] pixel_data_in, // data pins
  input wire logic enable_chain_a_in,   // chain a pin level
  output logic enable_chain_a_out,      // chain a drive value
  output logic enable_chain_a_oe,       // chain a driven
  input wire logic enable_chain_b_in,   // chain b pin level
  output logic enable_chain_b_out,      // chain b drive value
  output logic enable_chain_b_oe,       // chain b driven
  output logic [159:0][2:0] drive_outputs // level code per output
);

  // pin synchronisers and filter
  lcrd_pkg::lcrd_pins_t pins_raw; // pins as a bundle
  lcrd_pkg::lcrd_pins_t sync1;    // first stage, read only by sync2
  lcrd_pkg::lcrd_pins_t sync2;    // second stage
  lcrd_pkg::lcrd_pins_t sync3;    // third stage
  lcrd_pkg::lcrd_pins_t filt;     // accepted pin levels
  lcrd_pkg::lcrd_pins_t filt_q;   // accepted levels one cycle back
  lcrd_pkg::lcrd_pins_t next_filt;

  // control and sequence state
  logic [31:0] ctrl;                  // control register
  lcrd_pkg::lcrd_state_t state;       // column capture state
  lcrd_pkg::lcrd_state_t next_state;
  logic [5:0] count;                  // next group index
  logic col_out_n;                    // column chain output, active low
  logic [159:0] col_bits;             // shifted-in line
  logic [159:0] lat;                  // latched line
  logic [159:0] tok;                  // row token chain
  logic [159:0] next_tok;
  logic [159:0] wr_mask;
  logic [159:0] wr_val;

  // two-entry buffer between capture and line store
  lcrd_pkg::lcrd_entry_t buf_mem [2]; // entries
  logic wr_ptr;                       // fill pointer
  logic rd_ptr;                       // drain pointer
  logic [1:0] fill_cnt;               // occupancy

  // pin bundle
  assign pins_raw = '{mode_select, shift_dir, data_format_select, display_off_n, frame_polarity,
                      shift_clock, latch_pulse, pixel_data_in, enable_chain_a_in, enable_chain_b_in};

  // a change is taken once the second and third stages agree
  assign next_filt = lcrd_pkg::lcrd_pins_t'((~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt));

  // synchroniser and filter registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
      filt_q <= '0;
    end
    else
    begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      filt_q <= filt;
    end
  end

  // decoded modes and edges
  wire run = ctrl[`LCRD_CTRL_RUN_BIT];                  // block steps only while set
  wire col_mode = filt.mode_select;                     // [RULE1]
  wire dir_up = filt.shift_dir;
  wire fmt8 = filt.data_format_select;                  // [RULE7]
  wire scp_rise = filt.shift_clock & ~filt_q.shift_clock;
  wire lp_fall = ~filt.latch_pulse & filt_q.latch_pulse;
  wire chain_in = dir_up ? filt.chain_a_in : filt.chain_b_in; // [RULE6] [RULE12]
  wire [5:0] last_grp = fmt8 ? `LCRD_LAST_GRP8 : `LCRD_LAST_GRP4;
  wire col_step = col_mode & run;
  wire row_step = ~col_mode & run & lp_fall;            // [RULE10]

  // capture when enabled, or on the edge the enable arrives; done ignores data
  wire cap_evt = col_step & scp_rise & (state != lcrd_pkg::col_done)
                 & ((state == lcrd_pkg::col_capture) | ~chain_in); // [RULE11] [RULE16]
  wire fill_ready = (fill_cnt != 2'h2);                  // drops the capture when full
  wire cap_go = cap_evt & fill_ready;
  wire cap_last = cap_go & (count == last_grp);
  wire arm = col_step & (state == lcrd_pkg::col_idle) & ~chain_in
             & filt.shift_clock & filt.latch_pulse;     // [RULE4]
  wire drain_valid = (fill_cnt != 2'h0);
  wire drain_ready = ~lp_fall;                           // line store held while latching
  wire drain_go = drain_valid & drain_ready;
  lcrd_pkg::lcrd_entry_t head;
  assign head = buf_mem[rd_ptr];

  // column sequence next state
  always_comb
  begin
    next_state = state;
    if (!col_step || lp_fall)
      next_state = lcrd_pkg::col_idle;                   // new line starts after latch
    else if (cap_last)
      next_state = lcrd_pkg::col_done;                   // [RULE16]
    else if (cap_go || arm)
      next_state = lcrd_pkg::col_capture;                // [RULE4]
  end

  // column sequence registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= lcrd_pkg::col_idle;
      count <= 6'h00;
    end
    else
    begin
      state <= next_state;
      if (!col_step || lp_fall)
        count <= 6'h00;
      else if (cap_go)
        count <= count + 6'h01;                          // [RULE11]
    end
  end

  // chain output: low for one shift clock after the last group
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      col_out_n <= 1'b1;
    else if (cap_last)
      col_out_n <= 1'b0;                                 // [RULE16] [RULE17]
    else if (scp_rise || !col_mode)
      col_out_n <= 1'b1;                                 // [RULE17]
  end

  // buffer fill and drain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill_cnt <= 2'h0;
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end
    else
    begin
      if (cap_go)
      begin
        buf_mem[wr_ptr] <= '{count, filt.pixel_data};
        wr_ptr <= ~wr_ptr;
      end
      if (drain_go)
        rd_ptr <= ~rd_ptr;
      fill_cnt <= fill_cnt + {1'b0, cap_go} - {1'b0, drain_go};
    end
  end

  // per output: line-store write, token step and level choice
  genvar n;
  generate
    for (n = 0; n < `LCRD_NUM_OUT; n++)
    begin : g_out
      localparam int PUP = n;
      localparam int PDN = `LCRD_NUM_OUT - 1 - n;
      // group and data bit for this output in each direction and format
      wire hit4 = dir_up ? (head.grp == 6'(PUP / 4)) : (head.grp == 6'(PDN / 4));
      wire hit8 = dir_up ? (head.grp == 6'(PUP / 8)) : (head.grp == 6'(PDN / 8));
      wire bit4 = dir_up ? head.data[3 - (PUP % 4)] : head.data[3 - (PDN % 4)];
      wire bit8 = dir_up ? head.data[7 - (PUP % 8)] : head.data[7 - (PDN % 8)];
      assign wr_mask[n] = drain_go & (fmt8 ? hit8 : hit4);  // [RULE7] [RULE8]
      assign wr_val[n] = fmt8 ? bit8 : bit4;                // [RULE8]
      // token source from below (upward flow) and from above (downward flow)
      wire src_up;
      wire src_dn;
      if (n == 0)
        assign src_up = filt.chain_a_in;                    // [RULE12]
      else if (n == `LCRD_HALF)
        assign src_up = fmt8 ? filt.pixel_data[7] : tok[n - 1]; // [RULE14]
      else
        assign src_up = tok[n - 1];                         // [RULE13]
      if (n == `LCRD_NUM_OUT - 1)
        assign src_dn = filt.chain_b_in;                    // [RULE12]
      else if (n == `LCRD_HALF - 1)
        assign src_dn = fmt8 ? filt.pixel_data[7] : tok[n + 1]; // [RULE14]
      else
        assign src_dn = tok[n + 1];                         // [RULE13]
      assign next_tok[n] = dir_up ? src_up : src_dn;
      // frame and data pick the level; display off overrides
      wire d = col_mode ? lat[n] : tok[n];
      lcrd_pkg::lcrd_level_t next_lvl;
      assign next_lvl = !filt.display_off_n ? lcrd_pkg::level_5 :            // [RULE2]
                        col_mode ? (filt.frame_polarity ? (d ? lcrd_pkg::level_0 : lcrd_pkg::level_2)
                                                        : (d ? lcrd_pkg::level_5 : lcrd_pkg::level_3))
                                 : (filt.frame_polarity ? (d ? lcrd_pkg::level_5 : lcrd_pkg::level_1)
                                                        : (d ? lcrd_pkg::level_0 : lcrd_pkg::level_4)); // [RULE9]
      // output level register
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          drive_outputs[n] <= lcrd_pkg::level_5;
        else
          drive_outputs[n] <= next_lvl;
      end
    end
  endgenerate

  // line store, latch and token registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      col_bits <= '0;
      lat <= '0;
      tok <= '0;
    end
    else
    begin
      col_bits <= (col_bits & ~wr_mask) | (wr_val & wr_mask);
      if (col_step && lp_fall)
        lat <= col_bits;                                 // [RULE3]
      if (row_step)
        tok <= next_tok;                                 // [RULE10] [RULE13] [RULE14]
    end
  end

  // chain pins: the input side is never driven
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_chain_a_oe <= 1'b0;
      enable_chain_b_oe <= 1'b0;
      enable_chain_a_out <= 1'b1;
      enable_chain_b_out <= 1'b1;
    end
    else
    begin
      enable_chain_a_oe <= ~dir_up;                      // [RULE6] [RULE12]
      enable_chain_b_oe <= dir_up;                       // [RULE6] [RULE12]
      enable_chain_a_out <= col_mode ? col_out_n : tok[0];
      enable_chain_b_out <= col_mode ? col_out_n : tok[`LCRD_NUM_OUT - 1];
    end
  end

  // apb decode
  wire setup = psel & ~penable;
  wire acc_done = psel & penable & pready;
  wire hit_ctrl = (paddr == `LCRD_CTRL_OFS);
  wire hit_stat = (paddr == `LCRD_STATUS_OFS);
  wire [31:0] status = {20'h00000, fill_cnt, chain_in, 2'(state), count, col_mode};
  wire [31:0] rd_mux = hit_ctrl ? ctrl : (hit_stat ? status : 32'h00000000);

  // apb slave: answers in the cycle after setup, writes at the completing edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `LCRD_CTRL_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~(hit_ctrl | hit_stat);
      if (setup && !pwrite)
        prdata <= rd_mux;
      if (acc_done && pwrite && hit_ctrl)
        ctrl <= {31'h00000000, pwdata[`LCRD_CTRL_RUN_BIT]};
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_latch_fall;
    col_step && lp_fall;
  endsequence

  a_display_off_level: assert property (!filt.display_off_n |=> drive_outputs == {160{lcrd_pkg::level_5}}) // [RULE2]
    else $error("display off did not force level_5");
  a_latch_line: assert property (s_latch_fall |=> lat == $past(col_bits)) // [RULE3]
    else $error("line not latched on latch falling edge");
  a_first_enable: assert property (arm && !lp_fall |=> state == lcrd_pkg::col_capture) // [RULE4]
    else $error("enable not taken with chain low");
  a_column_pins: assert property (col_mode && dir_up |=> enable_chain_b_oe && !enable_chain_a_oe) // [RULE6]
    else $error("column chain roles wrong");
  a_row_pins: assert property (!col_mode && !dir_up |=> enable_chain_a_oe && !enable_chain_b_oe) // [RULE12]
    else $error("row chain roles wrong");
  a_column_level: assert property (col_mode && filt.display_off_n && filt.frame_polarity && lat[0]
                                   |=> drive_outputs[0] == lcrd_pkg::level_0) // [RULE9]
    else $error("column level wrong");
  a_group_count: assert property (cap_go && !lp_fall && !cap_last |=> count == $past(count) + 6'h01) // [RULE11]
    else $error("group count did not advance");
  a_row_shift_up: assert property (row_step && dir_up && !fmt8
                                   |=> tok[159:1] == $past(tok[158:0]) && tok[0] == $past(filt.chain_a_in)) // [RULE13]
    else $error("row token did not move up");
  a_dual_entry: assert property (row_step && dir_up && fmt8 |=> tok[80] == $past(filt.pixel_data[7])) // [RULE14]
    else $error("second token input not taken");
  a_done_ignores: assert property (state == lcrd_pkg::col_done && !lp_fall |-> !cap_evt) // [RULE16]
    else $error("data taken after full line");
  a_chain_pulse: assert property (col_mode && scp_rise && !cap_last |=> col_out_n) // [RULE17]
    else $error("chain pulse longer than one shift clock");
  a_chain_start: assert property (cap_last |=> !col_out_n) // [RULE17]
    else $error("chain pulse missing after last group");

endmodule : lcrd_driver
`default_nettype wire

// ---- rtl/lcrd_pkg.sv ----
// types of the lcd column and row driver front end
`default_nettype none
package lcrd_pkg;

  // drive level chosen for one output
  typedef enum logic [2:0] {level_0, level_1, level_2, level_3, level_4, level_5} lcrd_level_t;

  // column capture sequence
  typedef enum logic [1:0] {col_idle, col_capture, col_done} lcrd_state_t;

  // all pins that enter from outside the clock domain
  typedef struct packed {
    logic mode_select;        // high column, low row
    logic shift_dir;          // data flow direction
    logic data_format_select; // 4 or 8 bit, single or dual chain
    logic display_off_n;      // low forces level_5
    logic frame_polarity;     // frame signal
    logic shift_clock;        // column data clock
    logic latch_pulse;        // latch / row shift clock
    logic [7:0] pixel_data;   // data inputs, top used bit (3 or 7) is the first
    logic chain_a_in;         // enable_chain_a pin level
    logic chain_b_in;         // enable_chain_b pin level
  } lcrd_pins_t;

  // one captured column group waiting in the buffer
  typedef struct packed {
    logic [5:0] grp;          // group index within the line
    logic [7:0] data;         // raw data inputs
  } lcrd_entry_t;

endpackage : lcrd_pkg
`default_nettype wire

// ---- tb/lcrd_ctrl_model.sv ----
// lcd timing controller model that drives the link pins of the driver
`timescale 1ns/10ps
`default_nettype none
module lcrd_ctrl_model (
  input wire logic pclk,         // system clock, steps the model
  output logic shift_clock,      // column data clock
  output logic latch_pulse,      // latch and row clock
  output logic [7:0] pixel_data, // data pins
  output logic chain_a,          // level put on chain a when it is an input
  output logic chain_b           // level put on chain b when it is an input
);
  // clocks stand low outside frames, first driver's chain inputs tied low
  initial
  begin
    shift_clock = 1'b0;
    latch_pulse = 1'b0;
    pixel_data = 8'h00;
    chain_a = 1'b0;
    chain_b = 1'b0;
  end
  // wait a number of system clocks
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask : hold
  // one column group on a 320 ns shift clock; slow stretches the low time
  // the first edge keeps the new group apart from the previous group's stale data
  task automatic send_group(input logic [7:0] d, input int slow);
    hold(1);
    pixel_data <= d;
    hold(3 + slow);
    shift_clock <= 1'b1;
    hold(4);
    shift_clock <= 1'b0;
    pixel_data <= ~d; // hold time over, data no longer valid
  endtask : send_group
  // shift clock raised while the latch pulse is high: enables the first driver
  task automatic enable_first();
    latch_pulse <= 1'b1;
    hold(4);
    shift_clock <= 1'b1;
    hold(4);
    shift_clock <= 1'b0;
    hold(4);
    latch_pulse <= 1'b0;
    hold(8);
  endtask : enable_first
  // latch pulse; the fall is the active edge, data held well past it
  task automatic latch();
    latch_pulse <= 1'b1;
    hold(4);
    latch_pulse <= 1'b0;
    hold(8);
  endtask : latch
  // one row clock with token levels set up first; other data inputs fixed
  task automatic row_step(input logic ta, input logic tb, input logic din);
    chain_a <= ta;
    chain_b <= tb;
    pixel_data <= {din, 7'h00};
    hold(4);
    latch();
  endtask : row_step
endmodule : lcrd_ctrl_model
`default_nettype wire

// ---- tb/lcrd_driver_test.sv ----
// self-checking bench of the lcd column and row driver front end
`timescale 1ns/10ps
`default_nettype none
module lcrd_driver_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr; // apb side
  logic mode_select, shift_dir, data_format_select, display_off_n, frame_polarity; // mode pins
  logic scp, lp, ctl_a, ctl_b, a_out, a_oe, b_out, b_oe; // link pins
  logic [7:0] paddr, din; // address and data pins
  logic [31:0] pwdata, prdata, r; // bus data and random word
  logic [159:0][2:0] dout; // drive level codes
  logic [159:0] exp_dat; // expected data or token per output
  logic [32:0] exp_q[$]; // expected read answers, error flag on top
  logic [32:0] got; // oldest read note
  int fail_count, samples_checked, seed, w, q; // counters and loop helpers
  wire logic a_pin = a_oe ? a_out : ctl_a; // chain a wire level
  wire logic b_pin = b_oe ? b_out : ctl_b; // chain b wire level
  // 25 MHz system clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  lcrd_ctrl_model i_ctl (.pclk(pclk), .shift_clock(scp), .latch_pulse(lp), .pixel_data(din),
    .chain_a(ctl_a), .chain_b(ctl_b));
  lcrd_driver i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_select(mode_select), .shift_dir(shift_dir), .data_format_select(data_format_select),
    .display_off_n(display_off_n), .frame_polarity(frame_polarity), .shift_clock(scp), .latch_pulse(lp),
    .pixel_data_in(din), .enable_chain_a_in(a_pin), .enable_chain_a_out(a_out), .enable_chain_a_oe(a_oe),
    .enable_chain_b_in(b_pin), .enable_chain_b_out(b_out), .enable_chain_b_oe(b_oe), .drive_outputs(dout));
  // verdict and end of run
  task automatic tally_and_finish();
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // one comparison
  task automatic chk(input string name, input logic [32:0] e, input logic [32:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask : chk
  // level of one output from mode, frame, data and display state
  function automatic logic [2:0] lvl(input logic col, input logic fr, input logic d, input logic on);
    if (!on)
      return lcrd_pkg::level_5;
    case ({col, fr, d})
      3'b000: return lcrd_pkg::level_4;
      3'b001: return lcrd_pkg::level_0;
      3'b010: return lcrd_pkg::level_1;
      3'b011: return lcrd_pkg::level_5;
      3'b100: return lcrd_pkg::level_3;
      3'b101: return lcrd_pkg::level_5;
      3'b110: return lcrd_pkg::level_2;
      default: return lcrd_pkg::level_0;
    endcase
  endfunction : lvl
  // compare all drive outputs once pin changes have settled
  task automatic chk_outs(input logic col, input logic on);
    logic [2:0] e;
    repeat (8) @(posedge pclk);
    for (int n = 0; n < 160; n++)
    begin
      e = lvl(col, frame_polarity, exp_dat[n], on);
      samples_checked++;
      if (dout[n] !== e)
      begin
        fail_count++;
        $display("CHECK FAILED drive_outputs[%0d] expected %0d seen %0d", n, e, dout[n]);
      end
    end
  endtask : chk_outs
  // apb transfer; a read notes its expected answer first
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!wr)
      exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // read answers taken at the completing edge against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      got = exp_q.pop_front();
      chk("apb read", got, {pslverr, prdata});
    end
  // hang guard
  initial
  begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    seed = 32'hB9976E84;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    {mode_select, shift_dir, data_format_select, display_off_n, frame_polarity} = 5'h1B;
    exp_dat = '0;
    repeat (4) @(posedge pclk);
    chk_outs(1'b1, 1'b0);
    chk("reset oe", 33'h0, {a_oe, b_oe});
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0, 33'h000000001);
    apb(1'b1, 8'h08, 32'hFFFFFFFF, 33'h0);
    apb(1'b0, 8'h08, 32'h0, 33'h100000000);
    apb(1'b0, 8'h04, 32'h0, 33'h000000001);
    apb(1'b1, 8'h00, 32'h0, 33'h0);
    apb(1'b0, 8'h00, 32'h0, 33'h000000000);
    apb(1'b1, 8'h00, 32'h1, 33'h0);
    // column lines in every direction and format
    for (int c = 0; c < 4; c++)
    begin
      shift_dir <= c[0];
      data_format_select <= c[1];
      frame_polarity <= c[0] ^ c[1];
      w = c[1] ? 8 : 4;
      repeat (8) @(posedge pclk);
      chk("chain oe", {31'h0, ~c[0], c[0]}, {a_oe, b_oe});
      i_ctl.enable_first();
      for (int k = 0; k < 160 / w; k++)
      begin
        r = $random(seed);
        i_ctl.send_group(r[7:0], k % 3);
        for (int j = 0; j < w; j++)
          exp_dat[c[0] ? k * w + w - 1 - j : 159 - (k * w + w - 1 - j)] = r[j];
      end
      repeat (8) @(posedge pclk);
      chk("chain out low", 33'h0, c[0] ? b_out : a_out);
      apb(1'b0, 8'h04, 32'h0, c[1] ? 33'h000000129 : 33'h000000151);
      i_ctl.send_group(8'hA5, 0);
      repeat (4) @(posedge pclk);
      chk("chain out high", 33'h1, c[0] ? b_out : a_out);
      i_ctl.latch();
      chk_outs(1'b1, 1'b1);
    end
    display_off_n <= 1'b0;
    chk_outs(1'b1, 1'b0);
    display_off_n <= 1'b1;
    // row mode: stopped shifter first, then random token traffic
    mode_select <= 1'b0;
    exp_dat = '0;
    apb(1'b1, 8'h00, 32'h0, 33'h0);
    i_ctl.row_step(1'b1, 1'b1, 1'b1);
    chk_outs(1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'h1, 33'h0);
    for (int s = 0; s < 120; s++)
    begin
      q = s / 30;
      if (s % 30 == 0)
      begin
        shift_dir <= q[0];
        data_format_select <= q[1];
        repeat (8) @(posedge pclk);
      end
      r = $random(seed);
      frame_polarity <= r[3];
      i_ctl.row_step(r[0], r[1], r[2]);
      if (shift_dir)
      begin
        exp_dat = {exp_dat[158:0], r[0]};
        if (data_format_select)
          exp_dat[80] = r[2];
      end
      else
      begin
        exp_dat = {r[1], exp_dat[159:1]};
        if (data_format_select)
          exp_dat[79] = r[2];
      end
      chk_outs(1'b0, 1'b1);
      chk("token out", shift_dir ? exp_dat[159] : exp_dat[0], shift_dir ? b_out : a_out);
    end
    tally_and_finish();
  end
endmodule : lcrd_driver_test
`default_nettype wire
